// *** rtl/epu_cmd.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "epu_defines.svh"

module epu_cmd #(
  parameter int ADDR_W       = 14,
  parameter int MEM_BYTES    = 15000,
  parameter int STAGE_CYCLES = 16,
  parameter int FIFO_DEPTH   = 16
) (
  input  wire logic              clk_i,          // 125 MHz clock
  input  wire logic              rst_i,          // sync reset, high
  input  wire logic              byte_valid_i,   // host byte present
  input  wire logic              byte_dc_i,      // 0 opcode, 1 data
  input  wire logic [7:0]        byte_data_i,    // host byte
  output logic                   byte_ready_o,   // byte may be taken
  input  wire logic              rd_req_i,       // host read strobe
  output logic                   rd_valid_o,     // read byte pulse
  output logic      [7:0]        rd_data_o,      // read byte
  output logic                   mem_wr_valid_o, // memory write request
  output epu_pkg::epu_plane_t    mem_wr_plane_o, // write plane
  output logic      [ADDR_W-1:0] mem_wr_addr_o,  // write byte address
  output logic      [7:0]        mem_wr_data_o,  // write byte
  input  wire logic              mem_wr_ready_i, // memory takes write
  output logic                   mem_rd_req_o,   // memory read pulse
  output epu_pkg::epu_plane_t    mem_rd_plane_o, // read plane
  output logic      [ADDR_W-1:0] mem_rd_addr_o,  // read byte address
  input  wire logic [7:0]        mem_rd_data_i,  // data, cycle after req
  output epu_pkg::epu_src_t      mono_src_o,     // mono plane source
  output epu_pkg::epu_src_t      red_src_o,      // red plane source
  output logic      [7:0]        stage_sel_o,    // stored stage byte
  output logic                   busy_o,         // sequence running
  output logic                   clk_en_o,       // clock enabled
  output logic                   analog_en_o,    // analog enabled
  output logic                   temp_load_o,    // loading temperature
  output logic                   lut_load_o,     // loading waveform
  output logic                   drive_o,        // driving panel
  output logic                   mode2_o         // display mode 2
);

  localparam int SW = $clog2(STAGE_CYCLES + 1);

  function automatic epu_pkg::epu_src_t decode_opt(input logic [3:0] o);
    case (o)
      `EPU_OPT_NORMAL: decode_opt = epu_pkg::EPU_SRC_NORMAL;
      `EPU_OPT_ZERO:   decode_opt = epu_pkg::EPU_SRC_ZERO;
      `EPU_OPT_INVERT: decode_opt = epu_pkg::EPU_SRC_INVERT;
      default:         decode_opt = epu_pkg::EPU_SRC_UNDEF;
    endcase
  endfunction

  function automatic logic stage_on(input logic [2:0] s,
                                    input logic [7:0] sel);
    case (s)
      3'h1:    stage_on = sel[`EPU_STG_CLK_ON];
      3'h2:    stage_on = sel[`EPU_STG_TEMP];
      3'h3:    stage_on = sel[`EPU_STG_LUT];
      3'h4:    stage_on = sel[`EPU_STG_ANA_ON];
      3'h5:    stage_on = sel[`EPU_STG_DRIVE];
      3'h6:    stage_on = sel[`EPU_STG_ANA_OFF];
      3'h7:    stage_on = sel[`EPU_STG_OSC_OFF];
      default: stage_on = 1'b0;
    endcase
  endfunction

  // stages run in fixed order; disabled ones are skipped
  function automatic epu_pkg::epu_seq_t seq_next(input epu_pkg::epu_seq_t s,
                                                 input logic [7:0] sel);
    logic [2:0] i;
    logic       found;
    seq_next = epu_pkg::EPU_SEQ_IDLE;
    found    = 1'b0;
    for (int k = 1; k < 8; k++)
    begin
      i = 3'(k);
      if (!found && i > s && stage_on(i, sel))
      begin
        seq_next = epu_pkg::epu_seq_t'(i);
        found    = 1'b1;
      end
    end
  endfunction

  epu_pkg::epu_mem_wr_t fifo_in;
  epu_pkg::epu_mem_wr_t fifo_out;
  logic                 fifo_push;
  logic                 take;

  logic [7:0]           cmd;
  logic [7:0]           ctrl1;
  logic [7:0]           stage_sel;
  epu_pkg::epu_plane_t  rd_plane;
  logic [ADDR_W-1:0]    ptr;
  logic                 rd_first;
  logic                 rd_pend;
  logic                 rd_cap;
  epu_pkg::epu_seq_t    seq;
  logic [SW-1:0]        seq_cnt;
  logic [7:0]           run_sel;

  logic [7:0]           next_cmd;
  logic [7:0]           next_ctrl1;
  logic [7:0]           next_stage_sel;
  epu_pkg::epu_plane_t  next_rd_plane;
  logic [ADDR_W-1:0]    next_ptr;
  logic                 next_rd_first;
  logic                 next_rd_pend;
  logic                 next_rd_cap;
  epu_pkg::epu_seq_t    next_seq;
  logic [SW-1:0]        next_seq_cnt;
  logic [7:0]           next_run_sel;
  logic                 next_rd_valid;
  logic [7:0]           next_rd_data;
  logic                 next_mem_rd_req;
  logic                 next_clk_en;
  logic                 next_analog_en;
  logic [ADDR_W-1:0]    ptr_inc;

  always_comb
  begin
    take            = byte_valid_i && byte_ready_o;
    ptr_inc         = (ptr == ADDR_W'(MEM_BYTES - 1)) ? '0 : ptr + 1'b1;
    next_cmd        = cmd;
    next_ctrl1      = ctrl1;
    next_stage_sel  = stage_sel;
    next_rd_plane   = rd_plane;
    next_ptr        = ptr;
    next_rd_first   = rd_first;
    next_rd_pend    = rd_pend;
    next_rd_cap     = mem_rd_req_o;
    next_rd_valid   = 1'b0;
    next_rd_data    = rd_data_o;
    next_mem_rd_req = 1'b0;
    next_seq        = seq;
    next_seq_cnt    = seq_cnt;
    next_run_sel    = run_sel;
    fifo_push       = 1'b0;
    fifo_in.plane   = (cmd == `EPU_OP_WR_RED) ? epu_pkg::EPU_PLANE_RED
                                              : epu_pkg::EPU_PLANE_MONO;
    fifo_in.addr    = 14'(ptr);
    fifo_in.data    = byte_data_i;

    if (take && !byte_dc_i)
    begin
      next_cmd = byte_data_i;
      if (byte_data_i == `EPU_OP_WR_MONO || byte_data_i == `EPU_OP_WR_RED
          || byte_data_i == `EPU_OP_RD_RAM)
      begin
        next_ptr      = '0;
        next_rd_first = 1'b1;
        next_rd_pend  = 1'b0;
      end
      // a second activation while busy is ignored
      if (byte_data_i == `EPU_OP_ACTIVATE && seq == epu_pkg::EPU_SEQ_IDLE)
      begin
        next_run_sel = stage_sel;
        next_seq     = seq_next(epu_pkg::EPU_SEQ_IDLE, stage_sel);
        next_seq_cnt = '0;
      end
    end
    else if (take)
    begin
      case (cmd)
        `EPU_OP_UPD_CTRL1: next_ctrl1 = byte_data_i;
        `EPU_OP_UPD_CTRL2: next_stage_sel = byte_data_i;
        `EPU_OP_RD_SELECT:
          next_rd_plane = epu_pkg::epu_plane_t'(
                            byte_data_i[`EPU_RDSEL_BIT]);
        `EPU_OP_WR_MONO, `EPU_OP_WR_RED:
        begin
          fifo_push = 1'b1;
          next_ptr  = ptr_inc;
        end
        default: ;
      endcase
    end

    if (rd_req_i && cmd == `EPU_OP_RD_RAM && !rd_pend && (byte_dc_i || !take))
    begin
      if (rd_first)
      begin
        next_rd_first = 1'b0;
        next_rd_valid = 1'b1;
        next_rd_data  = `EPU_DUMMY_BYTE;
      end
      else
      begin
        next_mem_rd_req = 1'b1;
        next_rd_pend    = 1'b1;
        next_ptr        = ptr_inc;
      end
    end
    if (rd_cap)
    begin
      next_rd_valid = 1'b1;
      next_rd_data  = mem_rd_data_i;
      next_rd_pend  = 1'b0;
    end

    if (seq != epu_pkg::EPU_SEQ_IDLE)
    begin
      if (seq_cnt == SW'(STAGE_CYCLES - 1))
      begin
        next_seq     = seq_next(seq, run_sel);
        next_seq_cnt = '0;
      end
      else
        next_seq_cnt = seq_cnt + 1'b1;
    end

    next_clk_en    = clk_en_o;
    next_analog_en = analog_en_o;
    if (next_seq == epu_pkg::EPU_SEQ_CLK_ON)
      next_clk_en = 1'b1;
    if (next_seq == epu_pkg::EPU_SEQ_OSC_OFF)
      next_clk_en = 1'b0;
    if (next_seq == epu_pkg::EPU_SEQ_ANA_ON)
      next_analog_en = 1'b1;
    if (next_seq == epu_pkg::EPU_SEQ_ANA_OFF)
      next_analog_en = 1'b0;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cmd            <= `EPU_CMD_RST;
      ctrl1          <= `EPU_CTRL1_RST;
      stage_sel      <= `EPU_STAGE_RST;
      rd_plane       <= epu_pkg::EPU_PLANE_MONO;
      ptr            <= '0;
      rd_first       <= 1'b1;
      rd_pend        <= 1'b0;
      rd_cap         <= 1'b0;
      seq            <= epu_pkg::EPU_SEQ_IDLE;
      seq_cnt        <= '0;
      run_sel        <= `EPU_STAGE_RST;
      rd_valid_o     <= 1'b0;
      rd_data_o      <= `EPU_DUMMY_BYTE;
      mem_rd_req_o   <= 1'b0;
      mem_rd_plane_o <= epu_pkg::EPU_PLANE_MONO;
      mem_rd_addr_o  <= '0;
      mono_src_o     <= epu_pkg::EPU_SRC_NORMAL;
      red_src_o      <= epu_pkg::EPU_SRC_NORMAL;
      stage_sel_o    <= `EPU_STAGE_RST;
      busy_o         <= 1'b0;
      clk_en_o       <= 1'b0;
      analog_en_o    <= 1'b0;
      temp_load_o    <= 1'b0;
      lut_load_o     <= 1'b0;
      drive_o        <= 1'b0;
      mode2_o        <= 1'b0;
    end
    else
    begin
      cmd            <= next_cmd;
      ctrl1          <= next_ctrl1;
      stage_sel      <= next_stage_sel;
      rd_plane       <= next_rd_plane;
      ptr            <= next_ptr;
      rd_first       <= next_rd_first;
      rd_pend        <= next_rd_pend;
      rd_cap         <= next_rd_cap;
      seq            <= next_seq;
      seq_cnt        <= next_seq_cnt;
      run_sel        <= next_run_sel;
      rd_valid_o     <= next_rd_valid;
      rd_data_o      <= next_rd_data;
      mem_rd_req_o   <= next_mem_rd_req;
      mem_rd_plane_o <= rd_plane;
      mem_rd_addr_o  <= ptr;
      mono_src_o     <= decode_opt(next_ctrl1[`EPU_MONO_OPT_MSB:
                                              `EPU_MONO_OPT_LSB]);
      red_src_o      <= decode_opt(next_ctrl1[`EPU_RED_OPT_MSB:
                                              `EPU_RED_OPT_LSB]);
      stage_sel_o    <= next_stage_sel;
      busy_o         <= next_seq != epu_pkg::EPU_SEQ_IDLE;
      clk_en_o       <= next_clk_en;
      analog_en_o    <= next_analog_en;
      temp_load_o    <= next_seq == epu_pkg::EPU_SEQ_TEMP;
      lut_load_o     <= next_seq == epu_pkg::EPU_SEQ_LUT;
      drive_o        <= next_seq == epu_pkg::EPU_SEQ_DRIVE;
      mode2_o        <= next_run_sel[`EPU_STG_MODE2];
    end
  end

  // pixel bytes are buffered so a slow memory stalls the host, not drops data
  epu_fifo #(
    .WIDTH ($bits(epu_pkg::epu_mem_wr_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (fifo_push),
    .in_data_i   (fifo_in),
    .in_ready_o  (byte_ready_o),
    .out_valid_o (mem_wr_valid_o),
    .out_data_o  (fifo_out),
    .out_ready_i (mem_wr_ready_i)
  );

  assign mem_wr_plane_o = fifo_out.plane;
  assign mem_wr_addr_o  = ADDR_W'(fifo_out.addr);
  assign mem_wr_data_o  = fifo_out.data;

endmodule

`default_nettype wire

// *** rtl/epu_defines.svh ***
`ifndef EPU_DEFINES_SVH
`define EPU_DEFINES_SVH

// opcodes
`define EPU_OP_ACTIVATE   8'h20
`define EPU_OP_UPD_CTRL1  8'h21
`define EPU_OP_UPD_CTRL2  8'h22
`define EPU_OP_WR_MONO    8'h24
`define EPU_OP_WR_RED     8'h26
`define EPU_OP_RD_RAM     8'h27
`define EPU_OP_RD_SELECT  8'h41

// reset values
`define EPU_CTRL1_RST     8'h00
`define EPU_STAGE_RST     8'hFF
`define EPU_CMD_RST       8'h00
`define EPU_DUMMY_BYTE    8'h00

// plane option codes, one nibble each
`define EPU_OPT_NORMAL    4'h0
`define EPU_OPT_ZERO      4'h4
`define EPU_OPT_INVERT    4'h8

// fields of the update-control-1 byte
`define EPU_MONO_OPT_MSB  3
`define EPU_MONO_OPT_LSB  0
`define EPU_RED_OPT_MSB   7
`define EPU_RED_OPT_LSB   4

// stage-select bit positions
`define EPU_STG_CLK_ON    7
`define EPU_STG_ANA_ON    6
`define EPU_STG_TEMP      5
`define EPU_STG_LUT       4
`define EPU_STG_MODE2     3
`define EPU_STG_DRIVE     2
`define EPU_STG_ANA_OFF   1
`define EPU_STG_OSC_OFF   0

// read-select parameter bit: 0 mono plane, 1 red plane
`define EPU_RDSEL_BIT     0

`endif

// *** rtl/epu_pkg.sv ***
package epu_pkg;

  typedef enum logic [0:0] {
    EPU_PLANE_MONO = 1'b0,
    EPU_PLANE_RED  = 1'b1
  } epu_plane_t;

  typedef enum logic [1:0] {
    EPU_SRC_NORMAL = 2'b00,
    EPU_SRC_ZERO   = 2'b01,
    EPU_SRC_INVERT = 2'b10,
    EPU_SRC_UNDEF  = 2'b11
  } epu_src_t;

  typedef enum logic [2:0] {
    EPU_SEQ_IDLE    = 3'b000,
    EPU_SEQ_CLK_ON  = 3'b001,
    EPU_SEQ_TEMP    = 3'b010,
    EPU_SEQ_LUT     = 3'b011,
    EPU_SEQ_ANA_ON  = 3'b100,
    EPU_SEQ_DRIVE   = 3'b101,
    EPU_SEQ_ANA_OFF = 3'b110,
    EPU_SEQ_OSC_OFF = 3'b111
  } epu_seq_t;

  typedef struct packed {
    epu_plane_t  plane;
    logic [13:0] addr;
    logic [7:0]  data;
  } epu_mem_wr_t;

endpackage

// *** rtl/epu_fifo.sv ***
`timescale 1ns/100ps
`default_nettype none

// output word and ready come from registers; holds DEPTH words plus one
module epu_fifo #(
  parameter int WIDTH = 23,
  parameter int DEPTH = 16
) (
  input  wire logic             clk_i,       // clock
  input  wire logic             rst_i,       // sync reset, high
  input  wire logic             in_valid_i,  // write request
  input  wire logic [WIDTH-1:0] in_data_i,   // write word
  output logic                  in_ready_o,  // room for a word
  output logic                  out_valid_o, // word on output
  output logic      [WIDTH-1:0] out_data_o,  // output word
  input  wire logic             out_ready_i  // consumer takes word
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic [AW-1:0]    next_wr_ptr;
  logic [AW-1:0]    next_rd_ptr;
  logic [AW:0]      next_count;
  logic             next_out_valid;
  logic             next_in_ready;
  logic             push;
  logic             pop;

  always_comb
  begin
    push           = in_valid_i && in_ready_o;
    pop            = (!out_valid_o || out_ready_i) && (count != '0);
    next_wr_ptr    = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr    = pop ? rd_ptr + 1'b1 : rd_ptr;
    next_count     = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    next_out_valid = pop || (out_valid_o && !out_ready_i);
    next_in_ready  = next_count < (AW+1)'(DEPTH);
  end

  always_ff @(posedge clk_i)
  begin
    if (push)
      store[wr_ptr] <= in_data_i;
    if (pop)
      out_data_o <= store[rd_ptr];
    if (rst_i)
    begin
      wr_ptr      <= '0;
      rd_ptr      <= '0;
      count       <= '0;
      out_valid_o <= 1'b0;
      in_ready_o  <= 1'b0;
    end
    else
    begin
      wr_ptr      <= next_wr_ptr;
      rd_ptr      <= next_rd_ptr;
      count       <= next_count;
      out_valid_o <= next_out_valid;
      in_ready_o  <= next_in_ready;
    end
  end

endmodule

`default_nettype wire

// *** verification/epu_cmd_properties.sv ***
`timescale 1ns/100ps
`default_nettype none
module epu_cmd_properties (
  input wire logic                clk_i,          // clock
  input wire logic                rst_i,          // reset
  input wire logic                byte_valid_i,   // host byte
  input wire logic                byte_dc_i,      // 0 opcode
  input wire logic [7:0]          byte_data_i,    // byte value
  input wire logic                byte_ready_o,   // byte taken
  input wire logic                rd_req_i,       // read strobe
  input wire logic                rd_valid_o,     // read answer
  input wire logic [7:0]          rd_data_o,      // read byte
  input wire logic                mem_wr_valid_o, // write request
  input wire logic [7:0]          mem_wr_data_o,  // write byte
  input wire logic                mem_wr_ready_i, // write taken
  input wire logic                mem_rd_req_o,   // memory read
  input wire epu_pkg::epu_plane_t mem_rd_plane_o, // read plane
  input wire logic [7:0]          mem_rd_data_i,  // memory data
  input wire epu_pkg::epu_src_t   mono_src_o,     // mono source
  input wire epu_pkg::epu_src_t   red_src_o,      // red source
  input wire logic [7:0]          stage_sel_o,    // stage byte
  input wire logic                busy_o,         // running
  input wire logic                clk_en_o,       // clock on
  input wire logic                analog_en_o,    // analog on
  input wire logic                temp_load_o,    // temp stage
  input wire logic                lut_load_o,     // waveform stage
  input wire logic                drive_o         // drive stage
);
  logic [7:0] op;
  logic       first;
  logic       rsel;
  wire        take = byte_valid_i && byte_ready_o;

  function automatic epu_pkg::epu_src_t src_of(input logic [3:0] n);
    return (n == 4'h0) ? epu_pkg::EPU_SRC_NORMAL :
           (n == 4'h4) ? epu_pkg::EPU_SRC_ZERO :
           (n == 4'h8) ? epu_pkg::EPU_SRC_INVERT : epu_pkg::EPU_SRC_UNDEF;
  endfunction

  // the opcode in force, tracked at the host side of the buffer
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      op    <= 8'h00;
      first <= 1'b0;
      rsel  <= 1'b0;
    end
    else
    begin
      if (take && !byte_dc_i)
        op <= byte_data_i;
      if (take && !byte_dc_i)
        first <= (byte_data_i == 8'h27);
      else if (rd_req_i && op == 8'h27)
        first <= 1'b0;
      if (take && byte_dc_i && op == 8'h41)
        rsel <= byte_data_i[0];
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  stage_reset_a: assert property ($fell(rst_i) |-> stage_sel_o == 8'hFF)
    else $error("stage byte not FF after reset");
  src_reset_a: assert property ($fell(rst_i) |->
    mono_src_o == epu_pkg::EPU_SRC_NORMAL
    && red_src_o == epu_pkg::EPU_SRC_NORMAL)
    else $error("source options not normal after reset");
  stage_write_a: assert property (take && byte_dc_i && op == 8'h22
    |=> stage_sel_o == $past(byte_data_i))
    else $error("stage byte not stored");
  mono_opt_a: assert property (take && byte_dc_i && op == 8'h21
    |=> mono_src_o == src_of($past(byte_data_i[3:0])))
    else $error("mono option wrong");
  red_opt_a: assert property (take && byte_dc_i && op == 8'h21
    |=> red_src_o == src_of($past(byte_data_i[7:4])))
    else $error("red option wrong");
  dummy_read_a: assert property (rd_req_i && op == 8'h27 && first
    && (byte_dc_i || !take)
    |=> rd_valid_o && rd_data_o == 8'h00 && !mem_rd_req_o)
    else $error("dummy read wrong");
  mem_read_a: assert property (rd_req_i && op == 8'h27 && !first
    && (byte_dc_i || !take)
    |=> mem_rd_req_o ##2 rd_valid_o && rd_data_o == $past(mem_rd_data_i))
    else $error("memory read wrong");
  read_plane_a: assert property (mem_rd_req_o
    |-> mem_rd_plane_o == rsel)
    else $error("read plane wrong");
  busy_start_a: assert property (take && !byte_dc_i
    && byte_data_i == 8'h20 && !busy_o
    && (stage_sel_o & 8'hF7) != 8'h00 |=> busy_o)
    else $error("no busy");
  wr_hold_a: assert property (mem_wr_valid_o && !mem_wr_ready_i
    |=> mem_wr_valid_o && $stable(mem_wr_data_o)) else $error("write dropped");
  drive_on_a: assert property (drive_o |-> clk_en_o && analog_en_o)
    else $error("drive without clock and analog");
  load_on_a: assert property (temp_load_o || lut_load_o
    |-> clk_en_o && !drive_o) else $error("load stage wrong");

  cover property (busy_o && drive_o);
  cover property (rd_valid_o && !first);
  cover property (byte_valid_i && !byte_ready_o);
endmodule

bind epu_cmd epu_cmd_properties u_props (
  .clk_i(clk_i), .rst_i(rst_i), .byte_valid_i(byte_valid_i),
  .byte_dc_i(byte_dc_i), .byte_data_i(byte_data_i),
  .byte_ready_o(byte_ready_o), .rd_req_i(rd_req_i), .rd_valid_o(rd_valid_o),
  .rd_data_o(rd_data_o), .mem_wr_valid_o(mem_wr_valid_o),
  .mem_wr_data_o(mem_wr_data_o), .mem_wr_ready_i(mem_wr_ready_i),
  .mem_rd_req_o(mem_rd_req_o), .mem_rd_plane_o(mem_rd_plane_o),
  .mem_rd_data_i(mem_rd_data_i), .mono_src_o(mono_src_o),
  .red_src_o(red_src_o), .stage_sel_o(stage_sel_o), .busy_o(busy_o),
  .clk_en_o(clk_en_o), .analog_en_o(analog_en_o),
  .temp_load_o(temp_load_o), .lut_load_o(lut_load_o), .drive_o(drive_o));
`default_nettype wire

// *** verification/epu_host_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module epu_host_model (
  input  wire logic       clk_i,    // clock
  input  wire logic       ready_i,  // byte taken
  input  wire logic       rvalid_i, // read answer
  input  wire logic [7:0] rdata_i,  // read byte
  output logic            valid_o,  // byte present
  output logic            dc_o,     // 0 opcode, 1 data
  output logic [7:0]      data_o,   // byte
  output logic            rreq_o    // read strobe
);
  initial
  begin
    valid_o = 1'b0;
    dc_o    = 1'b0;
    data_o  = 8'h00;
    rreq_o  = 1'b0;
  end

  // select low marks an opcode; the byte stands until taken
  task automatic put(input logic dc, input logic [7:0] b);
    #1;
    valid_o = 1'b1;
    dc_o    = dc;
    data_o  = b;
    do @(posedge clk_i); while (ready_i !== 1'b1);
  endtask

  // a released bus must not keep showing the last byte
  task automatic idle();
    #1;
    valid_o = 1'b0;
    data_o  = ~data_o;
  endtask

  task automatic get(output logic [7:0] b, output logic ok);
    ok = 1'b0;
    b  = 8'h00;
    #1;
    rreq_o = 1'b1;
    @(posedge clk_i);
    #1;
    rreq_o = 1'b0;
    for (int i = 0; i < 8 && !ok; i++)
    begin
      @(posedge clk_i);
      if (rvalid_i === 1'b1)
      begin
        ok = 1'b1;
        b  = rdata_i;
      end
    end
  endtask
endmodule
`default_nettype wire

// *** verification/epu_cmd_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module epu_cmd_tb;
  localparam int SC = 4;
  localparam int N  = 24;
  logic clk_i, rst_i, bv, bdc, bready, rdreq, rdv, mwv, mwr, mrr, stall;
  logic busy, clken, anen, temp, lut, drv, mode2;
  logic [7:0] bdata, rdd, mwd, mrd, stg, b;
  logic [13:0] mwa, mra;
  epu_pkg::epu_plane_t mwp, mrp;
  epu_pkg::epu_src_t msrc, rsrc;
  logic [7:0] mem [2][256];
  logic [7:0] exp_m [N];
  logic [7:0] exp_r [N];
  logic [7:0] codes [6] = '{8'hC7, 8'hCF, 8'h91, 8'h99, 8'hB1, 8'hB9};
  int miscompares, check_count, refused;

  epu_cmd #(.STAGE_CYCLES(SC)) DUT (
    .clk_i(clk_i), .rst_i(rst_i), .byte_valid_i(bv), .byte_dc_i(bdc),
    .byte_data_i(bdata), .byte_ready_o(bready), .rd_req_i(rdreq),
    .rd_valid_o(rdv), .rd_data_o(rdd), .mem_wr_valid_o(mwv),
    .mem_wr_plane_o(mwp), .mem_wr_addr_o(mwa), .mem_wr_data_o(mwd),
    .mem_wr_ready_i(mwr), .mem_rd_req_o(mrr), .mem_rd_plane_o(mrp),
    .mem_rd_addr_o(mra), .mem_rd_data_i(mrd), .mono_src_o(msrc),
    .red_src_o(rsrc), .stage_sel_o(stg), .busy_o(busy), .clk_en_o(clken),
    .analog_en_o(anen), .temp_load_o(temp), .lut_load_o(lut),
    .drive_o(drv), .mode2_o(mode2));

  epu_host_model HOST (
    .clk_i(clk_i), .ready_i(bready), .rvalid_i(rdv), .rdata_i(rdd),
    .valid_o(bv), .dc_o(bdc), .data_o(bdata), .rreq_o(rdreq));

  initial
  begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  // frame memory: random stalls, read data one cycle after the request
  always @(posedge clk_i)
  begin
    if (mwv && mwr)
      mem[mwp][mwa[7:0]] <= mwd;
    if (mrr)
      mrd <= mem[mrp][mra[7:0]];
    if (bv && !bready)
      refused++;
    #1;
    mwr = !stall && ($urandom_range(0, 3) != 0);
  end

  task automatic check(input string what, input logic [7:0] seen, exp);
    check_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  function automatic logic [1:0] src_exp(input logic [3:0] n);
    return (n == 4'h0) ? 2'h0 : (n == 4'h4) ? 2'h1 : (n == 4'h8) ? 2'h2 : 2'h3;
  endfunction

  initial
  begin
    #100000;
    miscompares++;
    give_verdict();
  end

  initial
  begin
    logic [3:0] m, r;
    logic ok;
    int cnt;
    logic [2:0] seen;
    logic m2;
    b = $urandom(32'h3E59);
    rst_i = 1'b1;
    stall = 1'b0;
    mwr = 1'b0;
    mrd = 8'h00;
    repeat (2) @(posedge clk_i);
    #1 rst_i = 1'b0;
    repeat (2) @(posedge clk_i);
    check("stage reset", stg, 8'hFF);
    check("mono reset", msrc, 8'h00);
    check("red reset", rsrc, 8'h00);
    $display("test reset done");

    // listed codes first, then random ones; unlisted codes are expected to decode as undefined
    for (int i = 0; i < 6; i++)
    begin
      m = (i < 3) ? 4'(i * 4) : 4'($urandom);
      r = (i < 3) ? 4'((2 - i) * 4) : 4'($urandom);
      HOST.put(1'b0, 8'h21);
      HOST.put(1'b1, {r, m});
      HOST.idle();
      check("mono option", msrc, src_exp(m));
      check("red option", rsrc, src_exp(r));
    end
    b = $urandom;
    HOST.put(1'b0, 8'h22);
    HOST.put(1'b1, b);
    HOST.idle();
    check("stage byte", stg, b);
    $display("test options done");

    // memory held off long enough for the buffer to refuse bytes
    stall = 1'b1;
    fork
      begin
        repeat (60) @(posedge clk_i);
        stall = 1'b0;
      end
    join_none
    HOST.put(1'b0, 8'h24);
    for (int k = 0; k < N; k++)
    begin
      exp_m[k] = $urandom;
      HOST.put(1'b1, exp_m[k]);
    end
    HOST.put(1'b0, 8'h26);
    for (int k = 0; k < N; k++)
    begin
      exp_r[k] = $urandom;
      HOST.put(1'b1, exp_r[k]);
    end
    HOST.idle();
    HOST.get(b, ok);
    check("read refused", ok, 1'b0);
    for (cnt = 0; cnt < 200 && mwv !== 1'b0; cnt++)
      @(posedge clk_i);
    check("buffer drained", mwv, 1'b0);
    check("buffer refused", refused != 0, 1'b1);
    for (int k = 0; k < N; k++)
    begin
      check("mono memory", mem[0][k], exp_m[k]);
      check("red memory", mem[1][k], exp_r[k]);
    end
    $display("test writes done");

    for (int p = 0; p < 2; p++)
    begin
      HOST.put(1'b0, 8'h41);
      HOST.put(1'b1, 8'(p));
      HOST.put(1'b0, 8'h27);
      HOST.idle();
      HOST.get(b, ok);
      check("dummy byte", b, 8'h00);
      check("dummy answer", ok, 1'b1);
      for (int k = 0; k < N; k++)
      begin
        HOST.get(b, ok);
        check("read answer", ok, 1'b1);
        check("read byte", b, p ? exp_r[k] : exp_m[k]);
      end
    end
    $display("test reads done");

    foreach (codes[i])
    begin
      HOST.put(1'b0, 8'h22);
      HOST.put(1'b1, codes[i]);
      HOST.put(1'b0, 8'h20);
      HOST.idle();
      cnt = 0;
      seen = 3'h0;
      m2 = 1'b0;
      repeat (8 * SC + 4)
      begin
        @(posedge clk_i);
        cnt += busy;
        seen |= {drv, lut, temp};
        m2 |= mode2 & busy;
      end
      check("busy span", cnt, SC * $countones(codes[i] & 8'hF7));
      check("stages", seen, {codes[i][2], codes[i][4], codes[i][5]});
      check("mode", m2, codes[i][3]);
      check("enables off", {clken, anen}, 2'b00);
    end
    $display("test update done");
    give_verdict();
  end
endmodule
`default_nettype wire
